// >>> dv/prxirq_host.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bus host model, open-drain data line
// ----------------------------------------
module prxirq_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic oe
);
    import prxirq_pkg::*;
    localparam logic [7:0] WADR = {DEV_ADDR_DEF, 1'b0};
    int nak = 0;
    initial begin
        scl = 1'b1;
        oe = 1'b0;
    end
    // Wait core cycles, moves land on falling edges
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask : tk
    // One bit out, line read back in mid-high
    task automatic bx(input logic b, output logic r);
        oe = !b;
        tk(6);
        scl = 1'b1;
        tk(4);
        r = sda;
        tk(4);
        scl = 1'b0;
        tk(2);
    endtask : bx
    // Byte MSB first plus ninth bit; missing device ack counted
    task automatic bytex(input logic [7:0] d, input logic a, input logic c,
                         output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
        bx(a, r);
        if (c && r) nak++;
    endtask : bytex
    // Start or repeated start
    task automatic st();
        oe = 1'b0;
        tk(4);
        scl = 1'b1;
        tk(4);
        oe = 1'b1;
        tk(4);
        scl = 1'b0;
        tk(2);
    endtask : st
    // Stop, line released to the pull-up
    task automatic sp();
        oe = 1'b1;
        tk(4);
        scl = 1'b1;
        tk(4);
        oe = 1'b0;
        tk(4);
    endtask : sp
    // Write one data byte; clears use this too
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        st();
        bytex(WADR, 1'b1, 1'b1, q);
        bytex(a, 1'b1, 1'b1, q);
        bytex(d, 1'b1, 1'b1, q);
        sp();
    endtask : wreg
    // pointer first, then read two bytes
    task automatic rreg(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] q;
        st();
        bytex(WADR, 1'b1, 1'b1, q);
        bytex(a, 1'b1, 1'b1, q);
        st();
        bytex(WADR | 8'h01, 1'b1, 1'b1, q);
        bytex(8'hFF, 1'b0, 1'b0, v[15:8]);
        bytex(8'hFF, 1'b1, 1'b0, v[7:0]);
        sp();
    endtask : rreg
endmodule : prxirq_host
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import prxirq_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic afe_clk = 1'b0;
    logic afe_rst_b = 1'b0;
    logic afe_valid = 1'b0;
    logic afe_kind = 1'b0;
    logic [15:0] afe_data = 16'h0000;
    logic scl;
    logic host_oe;
    logic sda_o;
    logic sda_oe;
    logic int_o;
    logic int_oe;
    logic sda;
    logic [15:0] q;
    int num_errors = 0;
    int n_checks = 0;
    // Open-drain data wire with pull-up
    assign sda = !(sda_oe | host_oe);
    // Core clock and unrelated link clock
    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #3;
        forever #32 afe_clk = ~afe_clk;
    end
    prxirq_top prxirq_top_inst (.clk(clk), .rst_b(rst_b), .afe_clk(afe_clk),
        .afe_rst_b(afe_rst_b), .afe_valid(afe_valid), .afe_kind(afe_kind),
        .afe_data(afe_data), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe));
    prxirq_host prxirq_host_inst (.clk(clk), .sda(sda), .scl(scl), .oe(host_oe));
    // Compare and count
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        n_checks++;
        if (a !== e) begin
            num_errors++;
            $display("wrong value at %0t: expected %h got %h", $time, e, a);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        prxirq_host_inst.rreg(a, q);
        chk(e, q);
    endtask : rc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        prxirq_host_inst.wreg(a, d);
    endtask : wr
    // One result pulse, spaced wide enough not to be dropped
    task automatic afe(input logic k, input logic [15:0] d);
        @(negedge afe_clk);
        afe_valid = 1'b1;
        afe_kind = k;
        afe_data = d;
        @(negedge afe_clk);
        afe_valid = 1'b0;
        repeat (6) @(negedge afe_clk);
    endtask : afe
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        afe_rst_b = 1'b1;
        repeat (4) @(negedge clk);
        rc(8'h89, 16'h0000);
        rc(8'h8C, 16'h0000);
        rc(8'h85, 16'h0000);
        wr(8'h8A, 8'h12);
        wr(8'h8B, 8'h34);
        wr(8'h8C, 8'h56);
        wr(8'h8D, 8'h78);
        rc(8'h8A, 16'h1234);
        rc(8'h8C, 16'h5678);
        rc(8'h8B, 16'h3456);
        wr(8'h87, 8'hAA);
        rc(8'h87, 16'h0000);
        wr(8'h89, 8'hFF);
        rc(8'h89, 16'hEF12);
        wr(8'h89, 8'h08);
        afe(1'b0, 16'h0A5C);
        rc(8'h87, 16'h0A5C);
        rc(8'h8E, 16'h0800);
        chk(16'h0001, {15'h0, int_oe});
        wr(8'h8E, 8'h08);
        rc(8'h8E, 16'h0000);
        chk(16'h0000, {15'h0, int_oe});
        chk(16'h0000, {14'h0, sda_o, int_o});
        wr(8'h89, 8'h04);
        afe(1'b1, 16'h0001);
        rc(8'h8E, 16'h0400);
        wr(8'h8E, 8'h04);
        wr(8'h89, 8'h00);
        afe(1'b0, 16'h0002);
        rc(8'h8E, 16'h0000);
        // window resets count, restart after event
        wr(8'h89, 8'h42);
        for (int i = 0; i < 3; i++) afe(1'b0, 16'h6000);
        afe(1'b0, 16'h2000);
        for (int i = 0; i < 3; i++) afe(1'b0, 16'h6000);
        rc(8'h8E, 16'h0000);
        afe(1'b0, 16'h6000);
        rc(8'h8E, 16'h0100);
        wr(8'h8E, 8'h01);
        for (int i = 0; i < 3; i++) afe(1'b0, 16'h6000);
        rc(8'h8E, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr(8'h89, {3'(c), 5'h02});
            afe(1'b0, 16'h2000);
            for (int i = 1; i < (1 << c); i++) afe(1'b0, 16'h0000);
            rc(8'h8E, 16'h0000);
            afe(1'b0, 16'h0000);
            rc(8'h8E, 16'h0200);
            wr(8'h8E, 8'h02);
        end
        wr(8'h89, 8'h03);
        afe(1'b0, 16'h0000);
        rc(8'h8E, 16'h0000);
        afe(1'b1, 16'h0000);
        rc(8'h8E, 16'h0200);
        wr(8'h8E, 8'h02);
        wr(8'h89, 8'h00);
        afe(1'b0, 16'h0000);
        rc(8'h8E, 16'h0000);
        chk(16'h0000, 16'(prxirq_host_inst.nak));
        test_done();
    end
endmodule : tb
`default_nettype wire

// >>> rtl/prxirq_persist.sv
`timescale 1ns/1ns
`default_nettype none
module prxirq_persist (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic smp_valid,
    input wire logic [15:0] smp,
    input wire logic [15:0] lo_limit,
    input wire logic [15:0] hi_limit,
    input wire logic [2:0] code,
    output logic above_evt,
    output logic below_evt
);
    import prxirq_pkg::*;

    logic [7:0] cnt_r, cnt_nxt, need, cnt_inc;
    logic above_r, above_nxt, below_r, below_nxt;
    logic over_hi, under_lo;

    assign need = PERS_UNIT << code;
    assign cnt_inc = cnt_r + PERS_UNIT;
    assign over_hi = smp > hi_limit;
    assign under_lo = smp < lo_limit;

    // Count consecutive out-of-window samples
    always_comb begin
        cnt_nxt = cnt_r;
        above_nxt = 1'h0;
        below_nxt = 1'h0;
        if (smp_valid) begin
            if (over_hi || under_lo) begin
                // R2 persistence count reached
                if (cnt_inc >= need) begin
                    above_nxt = over_hi;
                    below_nxt = under_lo;
                    // R13 restart after event
                    cnt_nxt = BYTE_ZERO;
                end else begin
                    cnt_nxt = cnt_inc;
                end
            end else begin
                // R13 inside window clears
                cnt_nxt = BYTE_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= BYTE_ZERO;
            above_r <= 1'h0;
            below_r <= 1'h0;
        end else begin
            cnt_r <= cnt_nxt;
            above_r <= above_nxt;
            below_r <= below_nxt;
        end
    end

    assign above_evt = above_r;
    assign below_evt = below_r;

    a_fire_count: assert property ( // R2
        @(posedge clk) disable iff (!rst_b)
        $rose(above_r | below_r) |-> $past(cnt_r) + PERS_UNIT >= $past(need))
        else $error("threshold event before persistence count");
    a_range_clear: assert property ( // R13
        @(posedge clk) disable iff (!rst_b)
        smp_valid && !over_hi && !under_lo |=> cnt_r == BYTE_ZERO && !above_r && !below_r)
        else $error("in-window sample did not clear count");
endmodule : prxirq_persist
`default_nettype wire

// >>> rtl/prxirq_pkg.sv
`default_nettype none
package prxirq_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] PROX_HI_ADDR = 8'h87;
    localparam logic [7:0] PROX_LO_ADDR = 8'h88;
    localparam logic [7:0] CTRL_ADDR = 8'h89;
    localparam logic [7:0] LO_HI_ADDR = 8'h8A;
    localparam logic [7:0] LO_LO_ADDR = 8'h8B;
    localparam logic [7:0] HI_HI_ADDR = 8'h8C;
    localparam logic [7:0] HI_LO_ADDR = 8'h8D;
    localparam logic [7:0] STAT_ADDR = 8'h8E;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CNT_LSB = 5;
    localparam int PRDY_EN_BIT = 3;
    localparam int ARDY_EN_BIT = 2;
    localparam int THR_EN_BIT = 1;
    localparam int SEL_BIT = 0;
    localparam int ST_PRDY = 3;
    localparam int ST_ARDY = 2;
    localparam int ST_BELOW = 1;
    localparam int ST_ABOVE = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hEF;
    localparam logic [3:0] STAT_RST = 4'h0;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic [7:0] PERS_UNIT = 8'h01;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h13;
    localparam logic KIND_PROX = 1'h0;
    localparam logic KIND_ALS = 1'h1;

    // Serial slave states, Gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RECV = 3'h1,
        ST_ACK = 3'h3,
        ST_HOLD = 3'h2,
        ST_SEND = 3'h6,
        ST_SACK = 3'h7
    } prxirq_st_t;
endpackage : prxirq_pkg
`default_nettype wire

// >>> rtl/prxirq_result_cdc.sv
`timescale 1ns/1ns
`default_nettype none
module prxirq_result_cdc (
    input wire logic afe_clk,
    input wire logic afe_rst_b,
    input wire logic afe_valid,
    input wire logic afe_kind,
    input wire logic [15:0] afe_data,
    input wire logic clk,
    input wire logic rst_b,
    output logic res_valid,
    output logic res_kind,
    output logic [15:0] res_data
);
    import prxirq_pkg::*;

    logic req_r, req_nxt, kind_r, kind_nxt;
    logic [15:0] data_r, data_nxt;
    logic [1:0] ack_sync_r;
    logic [1:0] req_sync_r;
    logic ack_r, valid_r, rkind_r, rkind_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic busy, fresh;

    // ----------------------------------------
    // Front-end side: hold a result, toggle request
    // ----------------------------------------
    // Results offered while a transfer is open are dropped
    assign busy = req_r ^ ack_sync_r[1];

    always_comb begin
        req_nxt = req_r;
        kind_nxt = kind_r;
        data_nxt = data_r;
        if (afe_valid && !busy) begin
            req_nxt = ~req_r;
            kind_nxt = afe_kind;
            data_nxt = afe_data;
        end
    end

    always_ff @(posedge afe_clk) begin
        if (!afe_rst_b) begin
            req_r <= 1'h0;
            kind_r <= KIND_PROX;
            data_r <= WORD_RST;
            ack_sync_r <= 2'h0;
        end else begin
            req_r <= req_nxt;
            kind_r <= kind_nxt;
            data_r <= data_nxt;
            ack_sync_r <= {ack_sync_r[0], ack_r};
        end
    end

    // ----------------------------------------
    // Core side: detect toggle, take held word
    // ----------------------------------------
    assign fresh = req_sync_r[1] ^ ack_r;

    always_comb begin
        rkind_nxt = fresh ? kind_r : rkind_r;
        rdata_nxt = fresh ? data_r : rdata_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_sync_r <= 2'h0;
            ack_r <= 1'h0;
            valid_r <= 1'h0;
            rkind_r <= KIND_PROX;
            rdata_r <= WORD_RST;
        end else begin
            req_sync_r <= {req_sync_r[0], req_r};
            ack_r <= req_sync_r[1];
            valid_r <= fresh;
            rkind_r <= rkind_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign res_valid = valid_r;
    assign res_kind = rkind_r;
    assign res_data = rdata_r;
endmodule : prxirq_result_cdc
`default_nettype wire

// >>> rtl/prxirq_top.sv
// Function
// R1: Proximity result readable, high 87h, low 88h
// R2: Persistence code selects 1 to 128 samples
// R3: Proximity ready raises interrupt when enabled
// R4: Ambient ready raises interrupt when enabled
// R5: Threshold crossing raises interrupt when enabled
// R6: Select bit picks proximity or ambient source
// R7: Control register 89h, bit 4 unused
// R8: Low threshold bytes at 8Ah and 8Bh
// R9: High threshold bytes at 8Ch and 8Dh
// R10: Flags sticky, write one clears, pin low
// R11: Pointer advances after every read byte
// R12: Host writes pointer first, then reads
// R13: Counter clears in window, restarts after event
`timescale 1ns/1ns
`default_nettype none
module prxirq_top #(
    parameter logic [6:0] DEV_ADDR = prxirq_pkg::DEV_ADDR_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic afe_clk,
    input wire logic afe_rst_b,
    input wire logic afe_valid,
    input wire logic afe_kind,
    input wire logic [15:0] afe_data,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic int_o,
    output logic int_oe
);
    import prxirq_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [1:0] scl_sync_r, sda_sync_r;
    logic scl_q_r, sda_q_r, scl_s, sda_s;
    logic start_det, stop_det, scl_rise, scl_fall;
    prxirq_st_t st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shf_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, rd_byte;
    logic rw_r, rw_nxt, addr_ph_r, addr_ph_nxt, first_r, first_nxt;
    logic oe_r, oe_nxt, wr_en, rd_load;
    logic res_valid, res_kind;
    logic [15:0] res_data;
    logic smp_valid, above_evt, below_evt;
    logic [15:0] prox_r, prox_nxt, lo_r, lo_nxt, hi_r, hi_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [3:0] stat_r, stat_nxt, set_v, clr_v;
    logic int_oe_r, int_oe_nxt, int_o_r, sda_o_r;

    // ----------------------------------------
    // Pin synchronisers and bus conditions
    // ----------------------------------------
    // Two stages per pin, then one more for edge detection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_q_r <= 1'h1;
            sda_q_r <= 1'h1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_q_r <= scl_sync_r[1];
            sda_q_r <= sda_sync_r[1];
        end
    end

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;
    assign scl_rise = scl_s && !scl_q_r;
    assign scl_fall = !scl_s && scl_q_r;

    // ----------------------------------------
    // Result crossing and persistence
    // ----------------------------------------
    prxirq_result_cdc u_cdc (
        .afe_clk(afe_clk),
        .afe_rst_b(afe_rst_b),
        .afe_valid(afe_valid),
        .afe_kind(afe_kind),
        .afe_data(afe_data),
        .clk(clk),
        .rst_b(rst_b),
        .res_valid(res_valid),
        .res_kind(res_kind),
        .res_data(res_data)
    );

    // R6 source select for limits
    assign smp_valid = res_valid && (res_kind == ctrl_r[SEL_BIT]);

    prxirq_persist u_persist (
        .clk(clk),
        .rst_b(rst_b),
        .smp_valid(smp_valid),
        .smp(res_data),
        .lo_limit(lo_r),
        .hi_limit(hi_r),
        .code(ctrl_r[CNT_LSB+2:CNT_LSB]),
        .above_evt(above_evt),
        .below_evt(below_evt)
    );

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    always_comb begin
        case (ptr_r)
            // R1 result bytes
            PROX_HI_ADDR: rd_byte = prox_r[15:8];
            PROX_LO_ADDR: rd_byte = prox_r[7:0];
            CTRL_ADDR: rd_byte = ctrl_r;
            LO_HI_ADDR: rd_byte = lo_r[15:8];
            LO_LO_ADDR: rd_byte = lo_r[7:0];
            HI_HI_ADDR: rd_byte = hi_r[15:8];
            HI_LO_ADDR: rd_byte = hi_r[7:0];
            STAT_ADDR: rd_byte = {STAT_RST, stat_r};
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    // ----------------------------------------
    // Serial slave
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        shf_nxt = shift_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        addr_ph_nxt = addr_ph_r;
        first_nxt = first_r;
        oe_nxt = oe_r;
        wr_en = 1'h0;
        rd_load = 1'h0;
        if (stop_det) begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'h0;
        end else if (start_det) begin
            st_nxt = ST_RECV;
            bit_nxt = BIT_FIRST;
            addr_ph_nxt = 1'h1;
            oe_nxt = 1'h0;
        end else begin
            case (st_r)
                ST_IDLE: st_nxt = ST_IDLE;
                ST_RECV: if (scl_rise) begin
                    shf_nxt = {shift_r[6:0], sda_s};
                    if (bit_r == BIT_LAST) begin
                        st_nxt = ST_ACK;
                        bit_nxt = BIT_FIRST;
                    end else begin
                        bit_nxt = bit_r + BIT_STEP;
                    end
                end
                ST_ACK: if (scl_fall) begin
                    if (!addr_ph_r) begin
                        oe_nxt = 1'h1;
                        st_nxt = ST_HOLD;
                        // R12 first byte sets pointer
                        if (first_r) begin
                            ptr_nxt = shift_r;
                            first_nxt = 1'h0;
                        end else begin
                            wr_en = 1'h1;
                            ptr_nxt = ptr_r + PTR_STEP;
                        end
                    end else if (shift_r[7:1] == DEV_ADDR) begin
                        rw_nxt = shift_r[0];
                        addr_ph_nxt = 1'h0;
                        first_nxt = 1'h1;
                        oe_nxt = 1'h1;
                        st_nxt = ST_HOLD;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_HOLD: if (scl_fall) begin
                    if (rw_r) begin
                        // R11 advance after each read
                        rd_load = 1'h1;
                        tx_nxt = rd_byte;
                        ptr_nxt = ptr_r + PTR_STEP;
                        oe_nxt = ~rd_byte[7];
                        bit_nxt = BIT_FIRST;
                        st_nxt = ST_SEND;
                    end else begin
                        oe_nxt = 1'h0;
                        st_nxt = ST_RECV;
                    end
                end
                ST_SEND: if (scl_fall) begin
                    if (bit_r == BIT_LAST) begin
                        oe_nxt = 1'h0;
                        bit_nxt = BIT_FIRST;
                        st_nxt = ST_SACK;
                    end else begin
                        bit_nxt = bit_r + BIT_STEP;
                        tx_nxt = {tx_r[6:0], 1'h0};
                        oe_nxt = ~tx_r[6];
                    end
                end
                ST_SACK: if (scl_rise) begin
                    st_nxt = sda_s ? ST_IDLE : ST_HOLD;
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            bit_r <= BIT_FIRST;
            shift_r <= BYTE_ZERO;
            tx_r <= BYTE_ZERO;
            ptr_r <= BYTE_ZERO;
            rw_r <= 1'h0;
            addr_ph_r <= 1'h0;
            first_r <= 1'h0;
            oe_r <= 1'h0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            shift_r <= shf_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            addr_ph_r <= addr_ph_nxt;
            first_r <= first_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ----------------------------------------
    // Register file, flags and interrupt pin
    // ----------------------------------------
    always_comb begin
        prox_nxt = prox_r;
        ctrl_nxt = ctrl_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        clr_v = STAT_RST;
        // R1 result updated by front end only
        if (res_valid && res_kind == KIND_PROX) begin
            prox_nxt = res_data;
        end
        if (wr_en) begin
            case (ptr_r)
                // R7 control, unused bit kept zero
                CTRL_ADDR: ctrl_nxt = shift_r & CTRL_MASK;
                // R8 low threshold bytes
                LO_HI_ADDR: lo_nxt[15:8] = shift_r;
                LO_LO_ADDR: lo_nxt[7:0] = shift_r;
                // R9 high threshold bytes
                HI_HI_ADDR: hi_nxt[15:8] = shift_r;
                HI_LO_ADDR: hi_nxt[7:0] = shift_r;
                STAT_ADDR: clr_v = shift_r[3:0];
                default: clr_v = STAT_RST;
            endcase
        end
        // R3 proximity ready event
        set_v[ST_PRDY] = res_valid && res_kind == KIND_PROX && ctrl_r[PRDY_EN_BIT];
        // R4 ambient ready event
        set_v[ST_ARDY] = res_valid && res_kind == KIND_ALS && ctrl_r[ARDY_EN_BIT];
        // R5 threshold events
        set_v[ST_BELOW] = below_evt && ctrl_r[THR_EN_BIT];
        set_v[ST_ABOVE] = above_evt && ctrl_r[THR_EN_BIT];
        // R10 write one clears, set wins
        stat_nxt = (stat_r & ~clr_v) | set_v;
        int_oe_nxt = |stat_nxt;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prox_r <= WORD_RST;
            ctrl_r <= CTRL_RST;
            lo_r <= WORD_RST;
            hi_r <= WORD_RST;
            stat_r <= STAT_RST;
            int_oe_r <= 1'h0;
            int_o_r <= 1'h0;
            sda_o_r <= 1'h0;
        end else begin
            prox_r <= prox_nxt;
            ctrl_r <= ctrl_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            stat_r <= stat_nxt;
            int_oe_r <= int_oe_nxt;
            int_o_r <= 1'h0;
            sda_o_r <= 1'h0;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_o = sda_o_r;
    assign sda_oe = oe_r;
    assign int_o = int_o_r;
    assign int_oe = int_oe_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_int_level: assert property ( // R10
        @(posedge clk) disable iff (!rst_b) int_oe_r == (|stat_r))
        else $error("interrupt pin does not follow flags");
    a_w1c_clear: assert property ( // R10
        @(posedge clk) disable iff (!rst_b)
        wr_en && ptr_r == STAT_ADDR && shift_r[ST_ABOVE] && !set_v[ST_ABOVE]
        |=> !stat_r[ST_ABOVE])
        else $error("status bit not cleared by write one");
    a_prox_ready: assert property ( // R3
        @(posedge clk) disable iff (!rst_b)
        res_valid && res_kind == KIND_PROX && ctrl_r[PRDY_EN_BIT]
        |=> stat_r[ST_PRDY] && int_oe_r)
        else $error("proximity ready flag missing");
    a_als_ready: assert property ( // R4
        @(posedge clk) disable iff (!rst_b)
        res_valid && res_kind == KIND_ALS && ctrl_r[ARDY_EN_BIT] |=> stat_r[ST_ARDY])
        else $error("ambient ready flag missing");
    a_limit_flag: assert property ( // R5
        @(posedge clk) disable iff (!rst_b)
        below_evt && ctrl_r[THR_EN_BIT]
        |=> stat_r[ST_BELOW] ##1 (stat_r[ST_BELOW] || $past(clr_v[ST_BELOW])))
        else $error("low threshold flag missing or lost");
    a_src_match: assert property ( // R6
        @(posedge clk) disable iff (!rst_b)
        res_valid && res_kind != ctrl_r[SEL_BIT] |=> !$rose(above_evt | below_evt))
        else $error("threshold event from unselected source");
    a_ptr_advance: assert property ( // R11
        @(posedge clk) disable iff (!rst_b)
        rd_load |=> ptr_r == $past(ptr_r) + PTR_STEP && tx_r == $past(rd_byte))
        else $error("pointer did not advance after read");
    a_prox_ro: assert property ( // R1
        @(posedge clk) disable iff (!rst_b)
        wr_en && ptr_r == PROX_HI_ADDR && !res_valid |=> $stable(prox_r))
        else $error("proximity result written by host");
    a_ctrl_write: assert property ( // R7
        @(posedge clk) disable iff (!rst_b)
        wr_en && ptr_r == CTRL_ADDR |=> ctrl_r == ($past(shift_r) & CTRL_MASK))
        else $error("control register write wrong");
    a_low_write: assert property ( // R8
        @(posedge clk) disable iff (!rst_b)
        wr_en && ptr_r == LO_HI_ADDR |=> lo_r[15:8] == $past(shift_r))
        else $error("low threshold high byte not written");
    a_high_write: assert property ( // R9
        @(posedge clk) disable iff (!rst_b)
        wr_en && ptr_r == HI_LO_ADDR |=> hi_r[7:0] == $past(shift_r))
        else $error("high threshold low byte not written");
endmodule : prxirq_top
`default_nettype wire
